// ==== design/tam_monitor.sv ====
/*
  two-channel temperature converter controller with apb registers.
  assumes the converter macro raises i_conv_done for one cycle with valid
  i_conv_data while o_conv_trigger is held high.
*/
`timescale 1ns/1ps
module tam_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // converter macro
  output logic o_conv_power,
  output logic [2:0] o_conv_chan,
  output logic o_conv_trigger,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_data,
  // system outputs
  output logic o_irq,
  output logic o_overheat_reset,
  output logic o_overheat_pin
);

  tam_pkg::tam_regs_t q;
  tam_pkg::tam_regs_t next_q;
  logic [1:0] sticky;
  logic [1:0] next_sticky;
  logic setup;
  logic wr;
  logic c;
  logic above_hi;
  logic above_sh;
  logic below_lo;
  logic [7:0] hn;
  logic [7:0] sn;
  logic [1:0] watch;

  // consecutive-sample counter, saturating
  function automatic logic [7:0] deb_next(input logic [7:0] cnt,
                                          input logic above);
    if (!above) begin
      deb_next = '0;
    end else if (cnt == tam_pkg::DEB_MAX) begin
      deb_next = cnt;
    end else begin
      deb_next = cnt + 8'h01;
    end
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    setup = i_psel & ~i_penable;
    wr = i_psel & i_penable & i_pwrite;
    c = q.chan[0];
    watch = q.auto_c[tam_pkg::B_WATCH +: 2];
    // stored results compared; codes fall as temperature rises, so software
    // may set the invert select to make larger mean hotter
    above_hi = q.data[c] > q.hi[c];
    above_sh = q.data[c] > q.sh[c];
    below_lo = q.data[c] < q.lo[c];
    hn = deb_next(q.hcnt[c], above_hi);
    sn = deb_next(q.scnt[c], above_sh);

    // read data is registered in the setup phase
    next_q.pready = 1'b1;
    next_q.pslverr = 1'b0;
    if (setup) begin
      next_q.prdata = '0;
      case (i_paddr)
        tam_pkg::A_USER: begin
          next_q.prdata[12:0] = {q.busy, q.user};
        end
        tam_pkg::A_AUTO: begin
          next_q.prdata[13:0] = q.auto_c;
          next_q.prdata[16] = q.st != tam_pkg::ST_IDLE;
          next_q.prdata[17] = q.hot;
          next_q.prdata[tam_pkg::B_STICKY +: 2] = sticky;
        end
        tam_pkg::A_INTEN: next_q.prdata[16:0] = q.inten;
        tam_pkg::A_PEND: next_q.prdata[16:0] = q.pend;
        tam_pkg::A_DATA0: next_q.prdata[11:0] = q.data[0];
        tam_pkg::A_DATA1: next_q.prdata[11:0] = q.data[1];
        tam_pkg::A_HI0: next_q.prdata[11:0] = q.hi[0];
        tam_pkg::A_HI1: next_q.prdata[11:0] = q.hi[1];
        tam_pkg::A_SH0: next_q.prdata[11:0] = q.sh[0];
        tam_pkg::A_SH1: next_q.prdata[11:0] = q.sh[1];
        tam_pkg::A_HIDB: next_q.prdata[7:0] = q.hidb;
        tam_pkg::A_SHDB: next_q.prdata[7:0] = q.shdb;
        tam_pkg::A_PER: next_q.prdata = q.per;
        tam_pkg::A_PERHT: next_q.prdata = q.perht;
        tam_pkg::A_LO0: next_q.prdata[11:0] = q.lo[0];
        tam_pkg::A_LO1: next_q.prdata[11:0] = q.lo[1];
        default: next_q.pslverr = 1'b1;
      endcase
    end

    // register writes
    if (wr) begin
      case (i_paddr)
        tam_pkg::A_USER: next_q.user = i_pwdata[11:0];
        tam_pkg::A_AUTO: begin
          next_q.auto_c = i_pwdata[13:0] & tam_pkg::AUTO_WMASK;
        end
        tam_pkg::A_INTEN: begin
          next_q.inten = i_pwdata[16:0] & tam_pkg::INTEN_WMASK;
        end
        tam_pkg::A_PEND: begin
          next_q.pend = q.pend & ~(i_pwdata[16:0] & tam_pkg::W1C_MASK);
          if (!i_pwdata[tam_pkg::B_EOC]) begin
            next_q.pend[tam_pkg::B_EOC] = 1'b0;
          end
        end
        tam_pkg::A_HI0: next_q.hi[0] = i_pwdata[11:0];
        tam_pkg::A_HI1: next_q.hi[1] = i_pwdata[11:0];
        tam_pkg::A_SH0: next_q.sh[0] = i_pwdata[11:0];
        tam_pkg::A_SH1: next_q.sh[1] = i_pwdata[11:0];
        tam_pkg::A_HIDB: next_q.hidb = i_pwdata[7:0];
        tam_pkg::A_SHDB: next_q.shdb = i_pwdata[7:0];
        tam_pkg::A_PER: next_q.per = i_pwdata;
        tam_pkg::A_PERHT: next_q.perht = i_pwdata;
        tam_pkg::A_LO0: next_q.lo[0] = i_pwdata[11:0];
        tam_pkg::A_LO1: next_q.lo[1] = i_pwdata[11:0];
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // converter sequencing
    // ---------------------------------------------------------------
    next_q.busy = q.busy | q.trig;
    if (!q.auto_c[tam_pkg::B_AUTO_EN]) begin
      // user mode: software owns power and channel select
      next_q.st = tam_pkg::ST_IDLE;
      next_q.pwr = q.user[tam_pkg::B_PWR];
      next_q.chan = q.user[2:0];
      if (!q.user[tam_pkg::B_PWR]) begin
        next_q.armed = 1'b0;
        next_q.trig = 1'b0;
      end else if (q.user[tam_pkg::B_SMODE]) begin
        next_q.armed = 1'b0;
        next_q.trig = q.user[tam_pkg::B_START];
      end else if (!q.pwr) begin
        next_q.armed = 1'b1;
        next_q.dly = q.user[tam_pkg::B_DLY +: 6];
      end else if (q.armed) begin
        // start after the programmed power-up delay
        if (q.dly == '0) begin
          next_q.armed = 1'b0;
          next_q.trig = 1'b1;
        end else begin
          next_q.dly = q.dly - 6'h01;
        end
      end
    end else begin
      next_q.pwr = 1'b1;
      case (q.st)
        tam_pkg::ST_IDLE: begin
          if (|watch) begin
            next_q.chan = {2'b00, ~watch[0]};
            next_q.st = tam_pkg::ST_CONV;
            next_q.trig = 1'b1;
          end
        end
        tam_pkg::ST_CONV: ;
        tam_pkg::ST_EVAL: begin
          next_q.hcnt[c] = hn;
          next_q.scnt[c] = sn;
          if (above_hi && hn >= q.hidb) begin
            next_q.pend[tam_pkg::B_HI + int'(c)] = 1'b1;
          end
          if (above_sh && sn >= q.shdb) begin
            next_q.pend[tam_pkg::B_SH + int'(c)] = 1'b1;
          end
          if (below_lo && q.auto_c[tam_pkg::B_LTEN + int'(c)]) begin
            next_q.pend[tam_pkg::B_LO + int'(c)] = 1'b1;
          end
          // interval choice follows the latest result
          next_q.hot = above_hi | above_sh;
          next_q.cnt = next_q.hot ? q.perht : q.per;
          next_q.st = tam_pkg::ST_WAIT;
          if (watch[~c]) begin
            next_q.chan[0] = ~c;
          end else if (!watch[c]) begin
            next_q.st = tam_pkg::ST_IDLE;
          end
        end
        tam_pkg::ST_WAIT: begin
          if (q.cnt == '0) begin
            next_q.st = tam_pkg::ST_CONV;
            next_q.trig = 1'b1;
          end else begin
            next_q.cnt = q.cnt - 32'h1;
          end
        end
        default: next_q.st = tam_pkg::ST_IDLE;
      endcase
    end

    // end of conversion, applied after software clears so the set wins
    if (q.busy && i_conv_done) begin
      next_q.busy = 1'b0;
      next_q.trig = 1'b0;
      next_q.user[tam_pkg::B_START] = 1'b0;
      next_q.pend[tam_pkg::B_EOC] = 1'b1;
      next_q.data[c] = q.auto_c[tam_pkg::B_QSEL] ?
        12'(tam_pkg::Q_FULL - {1'b0, i_conv_data}) : i_conv_data;
      if (q.st == tam_pkg::ST_CONV) begin
        next_q.st = tam_pkg::ST_EVAL;
      end
    end

    // ---------------------------------------------------------------
    // system outputs
    // ---------------------------------------------------------------
    next_q.ovr = |(q.pend[tam_pkg::B_SH +: 2] &
                   q.inten[tam_pkg::B_RST_EN +: 2]);
    next_q.ovp = |(q.pend[tam_pkg::B_SH +: 2] &
                   q.inten[tam_pkg::B_PIN_EN +: 2]);
    next_q.irq = |(q.pend & q.inten & tam_pkg::IRQ_MASK);

    // history bits: only a write of one clears them, a new event wins
    next_sticky = sticky;
    if (wr && i_paddr == tam_pkg::A_AUTO) begin
      next_sticky = sticky & ~i_pwdata[tam_pkg::B_STICKY +: 2];
    end
    next_sticky = next_sticky | {q.ovr, q.ovp};
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.user <= tam_pkg::USER_RST;
      q.hidb <= tam_pkg::DB_RST;
      q.shdb <= tam_pkg::DB_RST;
      q.per <= tam_pkg::PER_RST;
      q.perht <= tam_pkg::PERHT_RST;
    end else begin
      q <= next_q;
    end
  end

  // kept across system reset on purpose
  always_ff @(posedge i_clk) begin
    sticky <= next_sticky;
  end

  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_conv_power = q.pwr;
  assign o_conv_chan = q.chan;
  assign o_conv_trigger = q.trig;
  assign o_irq = q.irq;
  assign o_overheat_reset = q.ovr;
  assign o_overheat_pin = q.ovp;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence conv_end;
    q.busy && i_conv_done;
  endsequence

  sequence eval_step;
    q.st == tam_pkg::ST_EVAL;
  endsequence

  done_flag_set_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    conv_end |=> q.pend[tam_pkg::B_EOC])
    else $error("done flag not set after conversion");

  done_flag_clr_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    wr && i_paddr == tam_pkg::A_PEND && !i_pwdata[tam_pkg::B_EOC]
    && !(q.busy && i_conv_done) |=> !q.pend[tam_pkg::B_EOC])
    else $error("done flag not cleared by zero write");

  result_store_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    conv_end ##0 (!q.auto_c[tam_pkg::B_QSEL]) |=>
    q.data[$past(q.chan[0])] == $past(i_conv_data))
    else $error("result not stored");

  hot_flag_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    eval_step ##0 (above_hi && hn >= q.hidb) |=>
    q.pend[tam_pkg::B_HI + int'($past(c))])
    else $error("hot flag missing");

  overheat_flag_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    eval_step ##0 (above_sh && sn >= q.shdb) |=>
    q.pend[tam_pkg::B_SH + int'($past(c))])
    else $error("overheat flag missing");

  cold_flag_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    eval_step ##0 (below_lo && q.auto_c[tam_pkg::B_LTEN + int'(c)]) |=>
    q.pend[tam_pkg::B_LO + int'($past(c))])
    else $error("cold flag missing");

  hot_debounce_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    eval_step ##0 (!q.pend[tam_pkg::B_HI + int'(c)] && hn < q.hidb
    && !wr) |=> !q.pend[tam_pkg::B_HI + int'($past(c))])
    else $error("hot flag before debounce count");

  interval_load_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    eval_step ##0 !wr |=>
    q.cnt == (q.hot ? $past(q.perht) : $past(q.per)))
    else $error("wrong poll interval loaded");

  reset_path_off_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    q.inten[tam_pkg::B_RST_EN +: 2] == 2'b00 |=> !o_overheat_reset)
    else $error("reset path driven while disabled");

  irq_level_a:
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    |(q.pend & q.inten & tam_pkg::IRQ_MASK) |=> o_irq)
    else $error("interrupt not raised");

endmodule

// ==== design/tam_pkg.sv ====
/*
  constants, register map and state types of the thermal monitor.
  assumes one 250 MHz clock and an apb slave port with byte addresses.
*/
// Functional notes
// - set done flag bit 16 when a conversion ends; writing zero clears it
// - per channel cold flag (bits 13/12) when result is below low threshold
// - per channel overheat flag (bits 5/4) when result is above shutdown
// - per channel hot flag (bits 1/0) when result exceeds high level
// - latest 12-bit result per channel readable; upper bits read zero
// - writable 12-bit high level per channel, reset zero
// - writable 12-bit shutdown level per channel drives overheat condition
// - hot flag after debounce count of consecutive high samples, reset 3
// - overheat after own debounce count of consecutive samples, reset 3
// - automatic mode waits normal interval between converter accesses
// - after a high or shutdown excess, hot interval is used instead
// - writable 12-bit low level per channel raises cold condition
// - start after delay field cycles, or follow software start bit
// - overheat drives reset path and pin path, each separately enabled
// - sensor codes fall as temperature rises, 3800 down to 3421
// - automatic control bit 0 selects user or automatic mode
// - watch bits 5 and 4 choose channels polled in turn
// - sticky overheat history bits 25/24 survive reset, write one clears
// - each overheat output stays low while its enable is clear
package tam_pkg;
  // register offsets
  localparam logic [7:0] A_USER = 8'h00;
  localparam logic [7:0] A_AUTO = 8'h04;
  localparam logic [7:0] A_INTEN = 8'h08;
  localparam logic [7:0] A_PEND = 8'h0C;
  localparam logic [7:0] A_DATA0 = 8'h20;
  localparam logic [7:0] A_DATA1 = 8'h24;
  localparam logic [7:0] A_HI0 = 8'h30;
  localparam logic [7:0] A_HI1 = 8'h34;
  localparam logic [7:0] A_SH0 = 8'h40;
  localparam logic [7:0] A_SH1 = 8'h44;
  localparam logic [7:0] A_HIDB = 8'h60;
  localparam logic [7:0] A_SHDB = 8'h64;
  localparam logic [7:0] A_PER = 8'h68;
  localparam logic [7:0] A_PERHT = 8'h6C;
  localparam logic [7:0] A_LO0 = 8'h80;
  localparam logic [7:0] A_LO1 = 8'h84;
  // reset values
  localparam logic [11:0] USER_RST = 12'h208;
  localparam logic [7:0] DB_RST = 8'h03;
  localparam logic [31:0] PER_RST = 32'h0001_0000;
  localparam logic [31:0] PERHT_RST = 32'h0001_0000;
  // field positions and masks
  localparam int B_PWR = 3;
  localparam int B_SMODE = 4;
  localparam int B_START = 5;
  localparam int B_DLY = 6;
  localparam int B_AUTO_EN = 0;
  localparam int B_QSEL = 1;
  localparam int B_WATCH = 4;
  localparam int B_LTEN = 12;
  localparam int B_STICKY = 24;
  localparam int B_PIN_EN = 4;
  localparam int B_RST_EN = 8;
  localparam int B_HI = 0;
  localparam int B_SH = 4;
  localparam int B_LO = 12;
  localparam int B_EOC = 16;
  localparam logic [13:0] AUTO_WMASK = 14'h3133;
  localparam logic [16:0] INTEN_WMASK = 17'h1_3333;
  localparam logic [16:0] W1C_MASK = 17'h0_3033;
  localparam logic [16:0] IRQ_MASK = 17'h1_3003;
  localparam logic [7:0] DEB_MAX = 8'hFF;
  localparam logic [12:0] Q_FULL = 13'h1000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_EVAL = 2'b11,
    ST_WAIT = 2'b10
  } tam_state_t;

  typedef struct packed {
    tam_state_t st;
    logic [11:0] user;
    logic [13:0] auto_c;
    logic [16:0] inten;
    logic [16:0] pend;
    logic [1:0][11:0] data;
    logic [1:0][11:0] hi;
    logic [1:0][11:0] sh;
    logic [1:0][11:0] lo;
    logic [7:0] hidb;
    logic [7:0] shdb;
    logic [31:0] per;
    logic [31:0] perht;
    logic [31:0] cnt;
    logic [1:0][7:0] hcnt;
    logic [1:0][7:0] scnt;
    logic [5:0] dly;
    logic armed;
    logic hot;
    logic busy;
    logic trig;
    logic pwr;
    logic [2:0] chan;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ovr;
    logic ovp;
  } tam_regs_t;
endpackage

// ==== tb/tam_conv_model.sv ====
/*
  behavioural model of the sensor converter macro.
  assumes the monitor holds its trigger high until it sees one done pulse.
*/
`timescale 1ns/1ps
module tam_conv_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // request from the monitor
  input wire logic i_trigger,
  // code to return and answer speed
  input wire logic [11:0] i_code,
  input wire logic i_slow,
  // answer
  output logic o_done,
  output logic [11:0] o_data
);
  logic [3:0] wait_cnt;
  logic [11:0] last;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_cnt <= 4'h0;
      o_done <= 1'h0;
      o_data <= 12'h000;
      last <= 12'h000;
    end else begin
      o_done <= 1'h0;
      // data bus is not held outside the done cycle
      o_data <= ~last;
      if (i_trigger && !o_done) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == (i_slow ? 4'h7 : 4'h2)) begin
          o_done <= 1'h1;
          o_data <= i_code;
          last <= i_code;
          wait_cnt <= 4'h0;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule

// ==== tb/tam_monitor_tb.sv ====
/*
  self-checking bench of the thermal monitor.
  assumes the converter model answers every trigger with one done pulse.
*/
`timescale 1ns/1ps
module tam_monitor_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [11:0] HI = 12'h800;
  localparam logic [11:0] SH = 12'hA00;
  localparam logic [11:0] LO = 12'h400;
  localparam int PER = 40;
  localparam int PERHT = 70;
  logic i_clk = 1'h0;
  logic i_arst_n = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic slow = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, er, pwrc, trig, done, irq, ovr, ovp;
  logic [2:0] chan;
  logic [11:0] cdata;
  logic [11:0] code0 = 12'h000;
  logic [11:0] code1 = 12'h000;
  integer seed = 32'hD42D;
  int num_errors = 0;
  int n_tests = 0;
  int ndone = 0;
  int cyc = 0;
  int tlast = 0;
  int gap = 0;
  int i, g1;

  always #2 i_clk = ~i_clk;

  tam_monitor DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_conv_power(pwrc), .o_conv_chan(chan), .o_conv_trigger(trig),
    .i_conv_done(done), .i_conv_data(cdata), .o_irq(irq),
    .o_overheat_reset(ovr), .o_overheat_pin(ovp));

  tam_conv_model conv (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_trigger(trig), .i_code(chan[0] ? code1 : code0), .i_slow(slow),
    .o_done(done), .o_data(cdata));

  // spacing of done pulses in cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (done === 1'h1) begin
      ndone <= ndone + 1;
      gap <= cyc - tlast;
      tlast <= cyc;
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'h1;
    @(posedge i_clk);
    rd = prdata;
    er = pslverr;
    chk(pready, 32'h1);
    chk(er, a == 8'h10);
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic wait_done(input int n);
    int t;
    t = ndone + n;
    for (int k = 0; k < 4000 && ndone < t; k++) @(negedge i_clk);
    if (ndone < t) begin
      num_errors++;
      $display("unexpected hang at %0t: no conversion", $time);
      report_and_stop();
    end
  endtask

  // threshold register addresses in a fixed order
  function automatic logic [7:0] thr_addr(input int k);
    case (k)
      0: thr_addr = tam_pkg::A_HI0;
      1: thr_addr = tam_pkg::A_HI1;
      2: thr_addr = tam_pkg::A_SH0;
      3: thr_addr = tam_pkg::A_SH1;
      4: thr_addr = tam_pkg::A_LO0;
      default: thr_addr = tam_pkg::A_LO1;
    endcase
  endfunction

  // flags after k samples above both levels with debounce 2 and 3
  function automatic logic [31:0] exp_flags(input int k,
                                            input logic [11:0] c);
    exp_flags = 32'h0;
    exp_flags[0] = (c > HI) && k >= 2;
    exp_flags[4] = (c > SH) && k >= 3;
    exp_flags[12] = c < LO;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'h1;
    rdc(tam_pkg::A_HI0, ALL, 32'h0);
    rdc(tam_pkg::A_SH1, ALL, 32'h0);
    rdc(tam_pkg::A_HIDB, ALL, 32'h3);
    rdc(tam_pkg::A_SHDB, ALL, 32'h3);
    rdc(tam_pkg::A_PERHT, ALL, 32'h0001_0000);
    rdc(tam_pkg::A_LO1, ALL, 32'h0);
    rdc(tam_pkg::A_PEND, 32'hFFFF, 32'h0);
    rdc(8'h10, ALL, 32'h0);
    apb(1'h1, 8'h10, ALL);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      apb(1'h1, thr_addr(i), v);
      rdc(thr_addr(i), ALL, v & 32'hFFF);
    end
    apb(1'h1, tam_pkg::A_DATA0, ALL);
    rdc(tam_pkg::A_DATA0, ALL, 32'h0);
    // user mode, timed start on channel 1
    code1 <= 12'($random(seed));
    apb(1'h1, tam_pkg::A_USER, 32'h1);
    apb(1'h1, tam_pkg::A_USER, 32'h149);
    i = 0;
    while (trig !== 1'h1 && i < 100) begin
      @(negedge i_clk);
      i++;
    end
    if (trig !== 1'h1) begin
      num_errors++;
      $display("unexpected hang at %0t: no trigger", $time);
      report_and_stop();
    end
    // delay 5 plus three edges, seen at the negedge after the rise
    chk(i, 32'h8);
    chk({pwrc, chan}, 32'h9);
    wait_done(1);
    rdc(tam_pkg::A_DATA1, ALL, {20'h0, code1});
    rdc(tam_pkg::A_PEND, 32'h10000, 32'h10000);
    apb(1'h1, tam_pkg::A_PEND, 32'h0);
    rdc(tam_pkg::A_PEND, 32'h10000, 32'h0);
    // user mode, software start with a slow converter
    slow <= 1'h1;
    code0 <= 12'($random(seed));
    apb(1'h1, tam_pkg::A_USER, 32'h38);
    wait_done(1);
    rdc(tam_pkg::A_USER, 32'h20, 32'h0);
    rdc(tam_pkg::A_DATA0, ALL, {20'h0, code0});
    slow <= 1'h0;
    // automatic mode, programmed before the enable
    apb(1'h1, tam_pkg::A_PER, PER);
    apb(1'h1, tam_pkg::A_PERHT, PERHT);
    apb(1'h1, tam_pkg::A_HI0, {20'h0, HI});
    apb(1'h1, tam_pkg::A_SH0, {20'h0, SH});
    apb(1'h1, tam_pkg::A_LO0, {20'h0, LO});
    apb(1'h1, tam_pkg::A_HI1, 32'hFFF);
    apb(1'h1, tam_pkg::A_SH1, 32'hFFF);
    apb(1'h1, tam_pkg::A_LO1, 32'h0);
    apb(1'h1, tam_pkg::A_INTEN, 32'h1011);
    apb(1'h1, tam_pkg::A_HIDB, 32'h2);
    apb(1'h1, tam_pkg::A_SHDB, 32'h3);
    apb(1'h1, tam_pkg::A_PEND, 32'h0);
    code0 <= 12'h500 + 12'({$random(seed)} % 512);
    apb(1'h1, tam_pkg::A_AUTO, 32'h1011);
    wait_done(2);
    g1 = gap;
    rdc(tam_pkg::A_PEND, 32'h3033, 32'h0);
    chk(irq, 32'h0);
    code0 <= 12'hA01 + 12'({$random(seed)} % 1534);
    for (i = 1; i <= 3; i++) begin
      wait_done(1);
      repeat (4) @(negedge i_clk);
      rdc(tam_pkg::A_PEND, 32'h3033, exp_flags(i, code0));
    end
    chk(irq, 32'h1);
    chk(ovp, 32'h1);
    chk(ovr, 32'h0);
    apb(1'h1, tam_pkg::A_INTEN, 32'h1111);
    repeat (2) @(negedge i_clk);
    chk(ovr, 32'h1);
    wait_done(1);
    chk(gap - g1, PERHT - PER);
    rdc(tam_pkg::A_AUTO, 32'h300_0000, 32'h300_0000);
    // cold sample, then clear all flags by writing ones
    code0 <= 12'h3FF - 12'({$random(seed)} % 1023);
    wait_done(2);
    repeat (4) @(negedge i_clk);
    rdc(tam_pkg::A_PEND, 32'h1000, 32'h1000);
    code0 <= 12'h500 + 12'({$random(seed)} % 512);
    wait_done(2);
    apb(1'h1, tam_pkg::A_PEND, 32'h3033);
    rdc(tam_pkg::A_PEND, 32'h3033, 32'h0);
    chk({irq, ovp, ovr}, 32'h0);
    // both channels taken in turn
    code1 <= 12'h500 + 12'({$random(seed)} % 512);
    apb(1'h1, tam_pkg::A_AUTO, 32'h0);
    // inverted result select: stored value is 4096 minus the code
    apb(1'h1, tam_pkg::A_AUTO, 32'h1033);
    wait_done(3);
    rdc(tam_pkg::A_DATA1, ALL, {20'h0, 12'h000 - code1});
    rdc(tam_pkg::A_DATA0, ALL, {20'h0, 12'h000 - code0});
    // history bit survives a reset and clears on a written one
    @(posedge i_clk);
    i_arst_n <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'h1;
    rdc(tam_pkg::A_AUTO, 32'h300_0000, 32'h300_0000);
    apb(1'h1, tam_pkg::A_AUTO, 32'h300_0000);
    rdc(tam_pkg::A_AUTO, 32'h300_0000, 32'h0);
    report_and_stop();
  end
endmodule
